// >>> seq_pkg.sv
// Purpose: shared constants and types for the radio mode sequencer
// Assumes: 40 MHz clock, one clock domain
// Notes: chip modes, route codes, config and event bundles and timing counts
package seq_pkg;

	// chip operating modes driven out by the sequencer
	typedef enum logic [2:0] {
		MODE_SLEEP,
		MODE_STANDBY,
		MODE_SYNTH,
		MODE_TX,
		MODE_RX
	} chip_mode_t;

	// idle and low-power field encodings
	localparam logic IDLE_STANDBY = 1'b0;
	localparam logic IDLE_SLEEP = 1'b1;
	localparam logic LP_TO_OFF = 1'b0;
	localparam logic IDLE_TO_TX = 1'b0;
	localparam logic TX_TO_LPSEL = 1'b0;

	// launch route codes
	localparam logic [1:0] START_LPSEL = 2'h0;
	localparam logic [1:0] START_RX = 2'h1;
	localparam logic [1:0] START_TX = 2'h2;
	localparam logic [1:0] START_TX_ON_LEVEL = 2'h3;

	// receive exit codes
	localparam logic [2:0] RX_PKT_ON_PAYLOAD = 3'h1;
	localparam logic [2:0] RX_LPSEL_ON_PAYLOAD = 3'h2;
	localparam logic [2:0] RX_PKT_ON_CRC = 3'h3;
	localparam logic [2:0] RX_OFF_ON_STRENGTH = 3'h4;
	localparam logic [2:0] RX_OFF_ON_SYNC = 3'h5;
	localparam logic [2:0] RX_OFF_ON_PREAMBLE = 3'h6;

	// receive timeout action codes
	localparam logic [1:0] TMO_RESTART = 2'h0;
	localparam logic [1:0] TMO_TX = 2'h1;
	localparam logic [1:0] TMO_LPSEL = 2'h2;
	localparam logic [1:0] TMO_OFF = 2'h3;

	// packet-held exit codes
	localparam logic [2:0] PKT_OFF = 3'h0;
	localparam logic [2:0] PKT_TX_ON_DRAIN = 3'h1;
	localparam logic [2:0] PKT_LPSEL = 3'h2;
	localparam logic [2:0] PKT_RX_VIA_SYNTH = 3'h3;
	localparam logic [2:0] PKT_RX_DIRECT = 3'h4;

	// timer step encodings and durations
	localparam logic [1:0] STEP_OFF = 2'h0;
	localparam logic [1:0] STEP_FINE = 2'h1;
	localparam logic [1:0] STEP_MID = 2'h2;
	localparam int CLK_HZ = 40000000;
	localparam int STEP_FINE_US = 64;
	localparam int STEP_MID_US10 = 41;
	localparam int STEP_COARSE_MS = 262;
	// longest times round down
	localparam int STEP_FINE_CYC = STEP_FINE_US * (CLK_HZ / 1000000);
	localparam int STEP_MID_CYC = STEP_MID_US10 * (CLK_HZ / 10000);
	localparam int STEP_COARSE_CYC = STEP_COARSE_MS * (CLK_HZ / 1000);
	localparam int STEP_CNT_W = 24;
	localparam int MULT_W = 8;

	// sequencer configuration bundle
	typedef struct packed {
		logic idle_lowpower_choice;
		logic [1:0] launch_route;
		logic lowpower_choice;
		logic idle_exit_route;
		logic tx_exit_route;
		logic [2:0] rx_exit_route;
		logic [1:0] rx_timeout_route;
		logic [2:0] pkt_done_route;
		logic crc_check_on;
		logic crc_auto_discard;
		logic [1:0] first_timer_step;
		logic [1:0] second_timer_step;
		logic [MULT_W-1:0] first_timer_mult;
		logic [MULT_W-1:0] second_timer_mult;
	} seq_cfg_t;

	// event pulses from the radio blocks
	typedef struct packed {
		logic tx_done_event;
		logic payload_ready_event;
		logic crc_good_event;
		logic fifo_level_event;
		logic fifo_drained_event;
		logic strength_timeout_event;
		logic preamble_timeout_event;
		logic sync_timeout_event;
		logic strength_event;
		logic sync_match_event;
		logic preamble_seen_event;
	} seq_evt_t;

endpackage

// >>> seq_timer.sv
// Purpose: one sequencer interval timer
// Assumes: step count values set by the package
// Notes: counts step times mult after arm, then pulses done
`timescale 1ns/100ps
module seq_timer
(
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// control
	input wire logic arm_i,
	input wire logic stop_i,
	input wire logic [1:0] step_i,
	input wire logic [seq_pkg::MULT_W-1:0] mult_i,
	// result
	output logic done_o
);
	import seq_pkg::*;

	logic run_q;
	logic [STEP_CNT_W-1:0] tick_q;
	logic [MULT_W-1:0] left_q;
	logic [STEP_CNT_W-1:0] step_len;
	logic tick_end;

	always_comb
	begin
		case (step_i)
			STEP_FINE: step_len = STEP_CNT_W'(STEP_FINE_CYC - 1);
			STEP_MID: step_len = STEP_CNT_W'(STEP_MID_CYC - 1);
			default: step_len = STEP_CNT_W'(STEP_COARSE_CYC - 1);
		endcase
	end

	assign tick_end = (tick_q == step_len);

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			run_q <= 1'b0;
			tick_q <= '0;
			left_q <= '0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			if (stop_i)
				run_q <= 1'b0;
			else if (arm_i)
			begin
				// disabled step or zero multiplier never fires
				run_q <= (step_i != STEP_OFF) && (mult_i != '0);
				tick_q <= '0;
				left_q <= mult_i;
			end
			else if (run_q)
			begin
				if (tick_end)
				begin
					tick_q <= '0;
					if (left_q == MULT_W'(1))
					begin
						run_q <= 1'b0;
						done_o <= 1'b1;
					end
					left_q <= left_q - MULT_W'(1);
				end
				else
					tick_q <= tick_q + STEP_CNT_W'(1);
			end
		end
	end
endmodule

// >>> seq_top.sv
// Purpose: top level radio mode sequencer
// Assumes: event inputs are one-cycle pulses from logic on CLK_I
// Notes: mode request pins go to the chip mode controller
//
// What this block does
// - sequencer runs only while the FSK/OOK modem is selected
// - launch command in Sleep or Standby starts it and records initial mode
// - stop command forces the off state at once from any state
// - off via low-power choice returns chip to recorded initial mode
// - initial mode is captured at launch and used when a route picks off; stop or modem loss leaves the request unchanged
// - idle holds Standby when idle choice is 0, Sleep when 1
// - idle reacts only to first timer: 0 to transmit, 1 to receive
// - transmit turns transmitter on; receive and packet-held keep receiver on
// - launch route picks first step: low-power choice, rx, tx, tx on level
// - low-power choice 0 gives off in initial mode, 1 gives idle
// - packet sent exits transmit to low-power choice or receive
// - receive exit route picks payload, CRC, or detect-based exits
// - route 011 with CRC on, no auto discard: payload ready without CRC good is timeout
// - second timer always sends receive to low-power choice
// - strength, preamble or sync timeout each count as receive timeout
// - timeout route: restart rx, transmit, low-power choice, or off
// - packet-held route 000 off, 001 tx on drained, 010 low-power choice
// - route 011 returns to rx through synth mode, 100 directly
// - first timer fires step times mult after second timer or launch
// - second timer fires step times mult after first timer
// - step code: 00 off, 01 64 us, 10 4.1 ms, 11 262 ms
`timescale 1ns/100ps
module seq_top
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// host commands and configuration
	input wire logic SEQ_LAUNCH_CMD_I,
	input wire logic SEQ_STOP_CMD_I,
	input wire seq_pkg::seq_cfg_t CFG_I,
	// chip mode state
	input wire logic FSK_MODEM_SEL_I,
	input wire seq_pkg::chip_mode_t CHIP_MODE_I,
	// radio events
	input wire seq_pkg::seq_evt_t EVT_I,
	// mode requests and status
	output seq_pkg::chip_mode_t MODE_REQ_O,
	output logic MODE_REQ_VALID_O,
	output logic RX_RELAUNCH_O,
	output logic SEQ_ACTIVE_O,
	output logic [2:0] SEQ_STATE_O,
	output logic FIRST_TIMER_EVENT_O,
	output logic SECOND_TIMER_EVENT_O
);
	import seq_pkg::*;

	typedef enum logic [2:0] {
		SEQ_OFF_STATE,
		IDLE_STATE,
		TX_STATE,
		RX_STATE,
		PKT_HELD_STATE,
		LEVEL_WAIT_STATE,
		SYNTH_STATE
	} seq_state_t;

	seq_state_t state_q;
	seq_state_t state_d;
	chip_mode_t init_mode_q;
	chip_mode_t mode_d;
	logic mode_chg_d;
	logic relaunch_d;
	logic launch_ok;
	logic rx_timeout_event;
	logic first_timer_event;
	logic second_timer_event;
	logic lp_to_off;
	logic timers_arm;
	logic timers_stop;

	////////////////////////////////////////////////////////////////////
	// launch qualification and timeout merge

	assign launch_ok = SEQ_LAUNCH_CMD_I && !SEQ_STOP_CMD_I && FSK_MODEM_SEL_I
		&& (state_q == SEQ_OFF_STATE)
		&& (CHIP_MODE_I == MODE_SLEEP || CHIP_MODE_I == MODE_STANDBY);

	assign rx_timeout_event = EVT_I.strength_timeout_event || EVT_I.preamble_timeout_event
		|| EVT_I.sync_timeout_event;

	assign lp_to_off = (CFG_I.lowpower_choice == LP_TO_OFF);
	assign timers_arm = launch_ok;
	// leaving the FSK modem also halts the sequencer
	assign timers_stop = SEQ_STOP_CMD_I || !FSK_MODEM_SEL_I || (state_d == SEQ_OFF_STATE);

	////////////////////////////////////////////////////////////////////
	// interval timers alternate first and second

	seq_timer u_first_timer
	(
		.clk_i(CLK_I),
		.arst_n_i(ARST_N_I),
		.arm_i(timers_arm || second_timer_event),
		.stop_i(timers_stop),
		.step_i(CFG_I.first_timer_step),
		.mult_i(CFG_I.first_timer_mult),
		.done_o(first_timer_event)
	);

	seq_timer u_second_timer
	(
		.clk_i(CLK_I),
		.arst_n_i(ARST_N_I),
		.arm_i(first_timer_event),
		.stop_i(timers_stop || timers_arm),
		.step_i(CFG_I.second_timer_step),
		.mult_i(CFG_I.second_timer_mult),
		.done_o(second_timer_event)
	);

	////////////////////////////////////////////////////////////////////
	// next state and mode request

	always_comb
	begin
		state_d = state_q;
		mode_d = MODE_STANDBY;
		mode_chg_d = 1'b0;
		relaunch_d = 1'b0;
		if (SEQ_STOP_CMD_I || !FSK_MODEM_SEL_I)
		begin
			state_d = SEQ_OFF_STATE;
		end
		else
		begin
			case (state_q)
				SEQ_OFF_STATE:
				begin
					if (launch_ok)
					begin
						case (CFG_I.launch_route)
							START_RX: state_d = RX_STATE;
							START_TX: state_d = TX_STATE;
							START_TX_ON_LEVEL: state_d = LEVEL_WAIT_STATE;
							default: state_d = lp_to_off ? SEQ_OFF_STATE : IDLE_STATE;
						endcase
						if (CFG_I.launch_route == START_LPSEL && lp_to_off)
						begin
							mode_d = CHIP_MODE_I;
							mode_chg_d = 1'b1;
						end
					end
				end
				LEVEL_WAIT_STATE:
				begin
					if (EVT_I.fifo_level_event)
						state_d = TX_STATE;
				end
				IDLE_STATE:
				begin
					if (first_timer_event)
						state_d = (CFG_I.idle_exit_route == IDLE_TO_TX) ? TX_STATE : RX_STATE;
				end
				TX_STATE:
				begin
					if (EVT_I.tx_done_event)
					begin
						if (CFG_I.tx_exit_route == TX_TO_LPSEL)
							state_d = lp_to_off ? SEQ_OFF_STATE : IDLE_STATE;
						else
							state_d = RX_STATE;
					end
				end
				RX_STATE:
				begin
					if (second_timer_event)
						state_d = lp_to_off ? SEQ_OFF_STATE : IDLE_STATE;
					else if (rx_timeout_event || (CFG_I.rx_exit_route == RX_PKT_ON_CRC
						&& CFG_I.crc_check_on && !CFG_I.crc_auto_discard
						&& EVT_I.payload_ready_event && !EVT_I.crc_good_event))
					begin
						case (CFG_I.rx_timeout_route)
							TMO_RESTART:
							begin
								state_d = RX_STATE;
								relaunch_d = 1'b1;
							end
							TMO_TX: state_d = TX_STATE;
							TMO_LPSEL: state_d = lp_to_off ? SEQ_OFF_STATE : IDLE_STATE;
							default: state_d = SEQ_OFF_STATE;
						endcase
					end
					else
					begin
						case (CFG_I.rx_exit_route)
							RX_PKT_ON_PAYLOAD:
								if (EVT_I.payload_ready_event)
									state_d = PKT_HELD_STATE;
							RX_LPSEL_ON_PAYLOAD:
								if (EVT_I.payload_ready_event)
									state_d = lp_to_off ? SEQ_OFF_STATE : IDLE_STATE;
							RX_PKT_ON_CRC:
								if (EVT_I.crc_good_event)
									state_d = PKT_HELD_STATE;
							RX_OFF_ON_STRENGTH:
								if (EVT_I.strength_event)
									state_d = SEQ_OFF_STATE;
							RX_OFF_ON_SYNC:
								if (EVT_I.sync_match_event)
									state_d = SEQ_OFF_STATE;
							RX_OFF_ON_PREAMBLE:
								if (EVT_I.preamble_seen_event)
									state_d = SEQ_OFF_STATE;
							default: state_d = RX_STATE;
						endcase
					end
				end
				PKT_HELD_STATE:
				begin
					case (CFG_I.pkt_done_route)
						PKT_OFF: state_d = SEQ_OFF_STATE;
						PKT_TX_ON_DRAIN:
							if (EVT_I.fifo_drained_event)
								state_d = TX_STATE;
						PKT_LPSEL: state_d = lp_to_off ? SEQ_OFF_STATE : IDLE_STATE;
						PKT_RX_VIA_SYNTH: state_d = SYNTH_STATE;
						PKT_RX_DIRECT: state_d = RX_STATE;
						default: state_d = PKT_HELD_STATE;
					endcase
				end
				SYNTH_STATE: state_d = RX_STATE;
				default: state_d = SEQ_OFF_STATE;
			endcase
			// any active state routed to off hands the chip its initial mode
			if (state_q != SEQ_OFF_STATE && state_d == SEQ_OFF_STATE)
			begin
				mode_d = init_mode_q;
				mode_chg_d = 1'b1;
			end
			else if (state_d != state_q || relaunch_d)
			begin
				mode_chg_d = 1'b1;
				case (state_d)
					IDLE_STATE: mode_d = (CFG_I.idle_lowpower_choice == IDLE_SLEEP)
						? MODE_SLEEP : MODE_STANDBY;
					TX_STATE: mode_d = MODE_TX;
					RX_STATE: mode_d = MODE_RX;
					PKT_HELD_STATE: mode_d = MODE_RX;
					SYNTH_STATE: mode_d = MODE_SYNTH;
					default: mode_d = CHIP_MODE_I;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			state_q <= SEQ_OFF_STATE;
		else
			state_q <= state_d;
	end

	////////////////////////////////////////////////////////////////////
	// initial mode capture

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			init_mode_q <= MODE_STANDBY;
		else if (launch_ok)
			init_mode_q <= CHIP_MODE_I;
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			MODE_REQ_O <= MODE_STANDBY;
			MODE_REQ_VALID_O <= 1'b0;
			RX_RELAUNCH_O <= 1'b0;
		end
		else
		begin
			MODE_REQ_VALID_O <= mode_chg_d;
			RX_RELAUNCH_O <= relaunch_d;
			if (mode_chg_d)
				MODE_REQ_O <= mode_d;
		end
	end

	assign SEQ_ACTIVE_O = (state_q != SEQ_OFF_STATE);
	assign SEQ_STATE_O = state_q;
	assign FIRST_TIMER_EVENT_O = first_timer_event;
	assign SECOND_TIMER_EVENT_O = second_timer_event;
endmodule

// >>> seq_top_props.sv
// Purpose: port-level checks for the mode sequencer
// Assumes: one clock, async active-low reset, state codes 0 off up to 6 synth
// Notes: bound to seq_top after the module
`timescale 1ns/100ps
module seq_chk
	import seq_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// host side
	input wire logic SEQ_LAUNCH_CMD_I,
	input wire logic SEQ_STOP_CMD_I,
	input wire seq_pkg::seq_cfg_t CFG_I,
	input wire logic FSK_MODEM_SEL_I,
	input wire seq_pkg::chip_mode_t CHIP_MODE_I,
	input wire seq_pkg::seq_evt_t EVT_I,
	// outputs watched
	input wire seq_pkg::chip_mode_t MODE_REQ_O,
	input wire logic MODE_REQ_VALID_O,
	input wire logic RX_RELAUNCH_O,
	input wire logic SEQ_ACTIVE_O,
	input wire logic [2:0] SEQ_STATE_O,
	input wire logic FIRST_TIMER_EVENT_O,
	input wire logic SECOND_TIMER_EVENT_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);
	logic ok;
	logic off;
	logic go;
	logic tmo;
	assign ok = !SEQ_STOP_CMD_I && FSK_MODEM_SEL_I;
	assign off = SEQ_STATE_O == 3'h0;
	assign go = off && SEQ_LAUNCH_CMD_I && ok && CHIP_MODE_I inside {MODE_SLEEP, MODE_STANDBY};
	assign tmo = EVT_I.strength_timeout_event || EVT_I.preamble_timeout_event
		|| EVT_I.sync_timeout_event;
	////////////////////////////////////////////////////////////////
	AST_STOP_OFF: assert property (SEQ_STOP_CMD_I |=> off)
		else $error("stop did not reach off");
	AST_MODEM_OFF: assert property (!FSK_MODEM_SEL_I |=> off && !SEQ_ACTIVE_O)
		else $error("sequencer active without modem");
	AST_BAD_LAUNCH: assert property (off && SEQ_LAUNCH_CMD_I &&
		!(CHIP_MODE_I inside {MODE_SLEEP, MODE_STANDBY}) |=> off)
		else $error("launch taken outside low power");
	AST_LAUNCH_TX: assert property (go && CFG_I.launch_route == START_TX
		|=> SEQ_STATE_O == 3'h2 && MODE_REQ_VALID_O && MODE_REQ_O == MODE_TX)
		else $error("launch to transmit wrong");
	AST_IDLE_MODE: assert property (go && CFG_I.launch_route == START_LPSEL &&
		CFG_I.lowpower_choice |=> SEQ_STATE_O == 3'h1 &&
		MODE_REQ_O == (CFG_I.idle_lowpower_choice ? MODE_SLEEP : MODE_STANDBY))
		else $error("idle entry wrong");
	AST_TX_TO_RX: assert property (SEQ_STATE_O == 3'h2 && EVT_I.tx_done_event && ok &&
		CFG_I.tx_exit_route |=> SEQ_STATE_O == 3'h3)
		else $error("transmit exit wrong");
	AST_SYNTH_PATH: assert property (SEQ_STATE_O == 3'h4 && ok &&
		CFG_I.pkt_done_route == PKT_RX_VIA_SYNTH
		|=> SEQ_STATE_O == 3'h6 ##1 (!$past(ok) || SEQ_STATE_O == 3'h3))
		else $error("synth return path wrong");
	AST_RELAUNCH: assert property (SEQ_STATE_O == 3'h3 && ok && tmo &&
		CFG_I.rx_timeout_route == TMO_RESTART && CFG_I.second_timer_step == STEP_OFF
		|=> RX_RELAUNCH_O && SEQ_STATE_O == 3'h3)
		else $error("timeout restart wrong");
	AST_REQ_HOLD: assert property (!MODE_REQ_VALID_O |-> $stable(MODE_REQ_O))
		else $error("mode request moved without valid");
	AST_RX_MODE: assert property ((SEQ_STATE_O == 3'h3 || SEQ_STATE_O == 3'h4)
		|-> MODE_REQ_O == MODE_RX)
		else $error("receiver not requested in receive states");
	AST_SYNTH_MODE: assert property (SEQ_STATE_O == 3'h6 |-> MODE_REQ_O == MODE_SYNTH
		&& MODE_REQ_VALID_O)
		else $error("synth mode not requested");
	////////////////////////////////////////////////////////////////
	cover property (SEQ_STATE_O == 3'h6);
	cover property (RX_RELAUNCH_O);
	cover property (SEQ_STATE_O == 3'h5);
	cover property (SECOND_TIMER_EVENT_O && SEQ_STATE_O == 3'h3);
endmodule

bind seq_top seq_chk chk (.CLK_I, .ARST_N_I, .SEQ_LAUNCH_CMD_I, .SEQ_STOP_CMD_I, .CFG_I,
	.FSK_MODEM_SEL_I, .CHIP_MODE_I, .EVT_I, .MODE_REQ_O, .MODE_REQ_VALID_O, .RX_RELAUNCH_O,
	.SEQ_ACTIVE_O, .SEQ_STATE_O, .FIRST_TIMER_EVENT_O, .SECOND_TIMER_EVENT_O);

// >>> host_model.sv
// Purpose: host software writing the command bits
// Assumes: requests come from the test sequence
// Notes: stop wins if both are asked for
`timescale 1ns/100ps
module host_model
(
	// requests from the test sequence
	input wire logic launch_req_i,
	input wire logic stop_req_i,
	// command bits to the sequencer
	output logic launch_o,
	output logic stop_o
);
	// never both bits in one write
	assign launch_o = launch_req_i & ~stop_req_i;
	assign stop_o = stop_req_i;
endmodule

// >>> radio_mode_sequencer_tb_top.sv
// Purpose: self-checking bench for the mode sequencer
// Assumes: 40 MHz clock, state changes checked against a queue
// Notes: timers run at the 64 us step with small multipliers
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module radio_mode_sequencer_tb_top;
	import seq_pkg::*;
	logic clk = 0;
	logic rst_n = 0;
	logic lreq = 0;
	logic sreq = 0;
	logic sel = 1;
	logic launch, stop, vld, rlch, act, t1, t2;
	seq_cfg_t cfg = '0;
	chip_mode_t cm = MODE_STANDBY;
	seq_evt_t evt = '0;
	chip_mode_t req;
	logic [2:0] st;
	logic [2:0] prv = 3'h0;
	logic [2:0] exp_st;
	logic [2:0] q[$];
	int n_mismatch = 0;
	int compares = 0;
	int c;
	always #12.5 clk = ~clk;
	host_model host (.launch_req_i(lreq), .stop_req_i(sreq), .launch_o(launch), .stop_o(stop));
	seq_top dut (.CLK_I(clk), .ARST_N_I(rst_n), .SEQ_LAUNCH_CMD_I(launch),
		.SEQ_STOP_CMD_I(stop), .CFG_I(cfg), .FSK_MODEM_SEL_I(sel), .CHIP_MODE_I(cm),
		.EVT_I(evt), .MODE_REQ_O(req), .MODE_REQ_VALID_O(vld), .RX_RELAUNCH_O(rlch),
		.SEQ_ACTIVE_O(act), .SEQ_STATE_O(st), .FIRST_TIMER_EVENT_O(t1),
		.SECOND_TIMER_EVENT_O(t2));
	////////////////////////////////////////////////////////////////
	// monitor: each state change takes the oldest note
	always @(negedge clk)
		if (rst_n && st !== prv)
		begin
			if (q.size() == 0)
				`CHK("state", 3'h7, st)
			else
			begin
				exp_st = q.pop_front();
				`CHK("state", exp_st, st)
			end
			prv = st;
		end
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task note(input logic [2:0] s);
		if (s != 3'h7)
			q.push_back(s);
	endtask
	task ev(input seq_evt_t e, input logic [2:0] s);
		evt = e;
		note(s);
		@(posedge clk);
		evt <= '0;
		#1;
	endtask
	task go(input chip_mode_t m, input logic [2:0] s);
		cm = m;
		lreq = 1;
		note(s);
		@(posedge clk);
		lreq <= 0;
		#1;
	endtask
	task span(input logic which, input int n);
		c = 0;
		while ((which ? t2 : t1) !== 1'b1 && c < 20000)
		begin
			tick(1);
			c++;
		end
		`CHK("span", 1'b1, c >= n - 2 && c <= n + 2)
	endtask
	task halt(input string nm);
		sreq = 1;
		note(st != 3'h0 ? 3'h0 : 3'h7);
		tick(1);
		`CHK("stop_valid", 1'b0, vld)
		sreq = 0;
		tick(2);
		`CHK("drained", 0, q.size())
		$display("test %s done", nm);
	endtask
	task report_and_stop();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#1000000;
		n_mismatch++;
		report_and_stop();
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'h82e9));
		tick(2);
		rst_n = 1;
		cfg.launch_route = START_TX;
		cfg.tx_exit_route = 1'b1;
		cfg.rx_exit_route = RX_PKT_ON_PAYLOAD;
		cfg.pkt_done_route = PKT_RX_VIA_SYNTH;
		go(MODE_STANDBY, 3'h2);
		`CHK("active", 1'b1, act)
		`CHK("req", MODE_TX, req)
		ev(11'h400, 3'h3);
		ev(11'h200, 3'h4);
		note(3'h6);
		note(3'h3);
		tick(3);
		halt("tx_rx_synth");
		`CHK("req_kept", MODE_RX, req)
		cfg.launch_route = START_RX;
		cfg.rx_timeout_route = TMO_RESTART;
		go(MODE_SLEEP, 3'h3);
		ev(11'h010, 3'h7);
		`CHK("relaunch", 1'b1, rlch)
		cfg.rx_timeout_route = TMO_TX;
		ev(11'h020, 3'h2);
		ev(11'h400, 3'h3);
		cfg.rx_timeout_route = TMO_LPSEL;
		ev(11'h008, 3'h0);
		`CHK("initial", MODE_SLEEP, req)
		cfg.rx_timeout_route = TMO_OFF;
		go(MODE_STANDBY, 3'h3);
		ev(11'h010, 3'h0);
		halt("timeouts");
		for (int i = 4; i < 7; i++)
		begin
			cfg.rx_exit_route = 3'(i);
			go(MODE_STANDBY, 3'h3);
			ev(seq_evt_t'(11'h001 << (6 - i)), 3'h0);
		end
		cfg.rx_exit_route = RX_PKT_ON_CRC;
		cfg.crc_check_on = 1'b1;
		go(MODE_STANDBY, 3'h3);
		ev(11'h200, 3'h0);
		cfg.crc_auto_discard = 1'b1;
		go(MODE_STANDBY, 3'h3);
		ev(11'h200, 3'h7);
		ev(11'h008, 3'h0);
		cfg.crc_auto_discard = 1'b0;
		cfg.pkt_done_route = PKT_LPSEL;
		go(MODE_STANDBY, 3'h3);
		ev(11'h100, 3'h4);
		note(3'h0);
		tick(2);
		cfg.pkt_done_route = PKT_RX_DIRECT;
		go(MODE_STANDBY, 3'h3);
		ev(11'h100, 3'h4);
		note(3'h3);
		tick(2);
		cfg.pkt_done_route = PKT_OFF;
		ev(11'h100, 3'h4);
		note(3'h0);
		tick(2);
		cfg.pkt_done_route = PKT_TX_ON_DRAIN;
		go(MODE_STANDBY, 3'h3);
		ev(11'h100, 3'h4);
		tick(3);
		ev(11'h040, 3'h2);
		halt("rx_exits");
		go(MODE_TX, 3'h7);
		`CHK("bad_mode", 3'h0, st)
		sel = 0;
		go(MODE_STANDBY, 3'h7);
		`CHK("no_modem", 3'h0, st)
		sel = 1;
		cfg.launch_route = START_TX;
		go(MODE_STANDBY, 3'h2);
		sel = 0;
		note(3'h0);
		tick(2);
		sel = 1;
		halt("refusals");
		cfg.launch_route = START_TX_ON_LEVEL;
		cfg.tx_exit_route = TX_TO_LPSEL;
		go(MODE_SLEEP, 3'h5);
		ev(11'h400, 3'h7);
		ev(11'h080, 3'h2);
		`CHK("level_tx", MODE_TX, req)
		ev(11'h400, 3'h0);
		`CHK("tx_lp_off", MODE_SLEEP, req)
		`CHK("off_valid", 1'b1, vld)
		halt("level_start");
		cfg.launch_route = START_LPSEL;
		cfg.lowpower_choice = 1'b1;
		cfg.idle_lowpower_choice = IDLE_SLEEP;
		cfg.idle_exit_route = 1'b1;
		cfg.first_timer_step = STEP_FINE;
		cfg.second_timer_step = STEP_FINE;
		cfg.first_timer_mult = 8'(1 + $urandom % 3);
		cfg.second_timer_mult = 8'h01;
		go(MODE_STANDBY, 3'h1);
		`CHK("idle_mode", MODE_SLEEP, req)
		note(3'h3);
		span(1'b0, STEP_FINE_CYC * cfg.first_timer_mult);
		note(3'h1);
		span(1'b1, STEP_FINE_CYC);
		cfg.idle_exit_route = IDLE_TO_TX;
		note(3'h2);
		span(1'b0, STEP_FINE_CYC * cfg.first_timer_mult + 1);
		tick(3);
		`CHK("idle_tx", MODE_TX, req)
		halt("timers");
		report_and_stop();
	end
endmodule
